// >>> pkg/bct_pkg.sv
// Package: register map, field layout, reset values and states of the break count and branch trace block
`default_nettype none
package bct_pkg;
	// ==========================================
	// Register offsets (byte addresses, word aligned)
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_COUNT = 5'h04;
	localparam logic [4:0] OFF_SRC = 5'h08;
	localparam logic [4:0] OFF_IRQ_STAT = 5'h0c;
	localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
	localparam logic [4:0] OFF_TRACE = 5'h14;
	// ==========================================
	// Field positions
	localparam int BIT_TIMING = 6;
	localparam int BIT_SEQ = 3;
	localparam int BIT_CNT_EN = 0;
	localparam int BIT_TRACE_EN = 0;
	localparam int BIT_VALID = 31;
	localparam int CNT_W = 12;
	localparam int ADDR_W = 28;
	localparam int QUEUE_DEPTH = 4;
	localparam int IRQ_W = 3;
	localparam int IRQ_BREAK = 0;
	localparam int IRQ_CNT_HIT = 1;
	localparam int IRQ_BRANCH = 2;
	// ==========================================
	// Reset values and constants
	localparam logic [11:0] COUNT_RESET = 12'h000;
	localparam logic [11:0] COUNT_ONE = 12'h001;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// ==========================================
	// Bus slave states
	typedef enum logic [1:0] {BCT_IDLE, BCT_ANSWER} bct_bus_state_t;
endpackage : bct_pkg
`default_nettype wire

// >>> rtl/bct_src_queue.sv
// Four-entry branch source address queue with valid flags
`default_nettype none
module bct_src_queue
	import bct_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic branch,
	input wire logic [27:0] branch_addr,
	input wire logic clear_head,
	input wire logic clear_all,
	output logic [27:0] head_addr,
	output logic head_valid
);
	logic [27:0] addr_q [QUEUE_DEPTH];
	logic [QUEUE_DEPTH-1:0] valid_q;
	// ==========================================
	// Address storage carries no reset
	genvar i;
	generate
		for (i = 0; i < QUEUE_DEPTH; i++) begin : g_entry
			always_ff @(posedge clk_sys) begin
				if (branch) begin // see [RL13]
					addr_q[i] <= (i == 0) ? branch_addr : addr_q[(i == 0) ? 0 : i - 1]; // see [RL9] see [RL12]
				end
			end
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					valid_q[i] <= 1'b0; // see [RL11]
				end else if (clear_all) begin
					valid_q[i] <= 1'b0; // see [RL11]
				end else if (branch) begin
					valid_q[i] <= (i == 0) ? 1'b1 : valid_q[(i == 0) ? 0 : i - 1]; // see [RL10] see [RL13]
				end else if (clear_head && i == QUEUE_DEPTH - 1) begin
					valid_q[i] <= 1'b0; // see [RL11]
				end
			end
		end
	endgenerate
	// Oldest entry is what software reads
	assign head_addr = addr_q[QUEUE_DEPTH-1];
	assign head_valid = valid_q[QUEUE_DEPTH-1];
endmodule : bct_src_queue
`default_nettype wire

// >>> rtl/bct_count_break.sv
// Channel B execution-count down-counter and sequential match tracking
`default_nettype none
module bct_count_break
	import bct_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic match_a,
	input wire logic match_b,
	input wire logic seq_sel,
	input wire logic cnt_en,
	input wire logic cnt_wr,
	input wire logic [11:0] cnt_wdata,
	output logic [11:0] count,
	output logic fire_b,
	output logic fire_a
);
	logic [11:0] count_q;
	logic a_seen_q;
	logic b_ok;
	logic b_cond;
	logic cnt_last;
	assign b_ok = match_b && (!seq_sel || a_seen_q); // see [RL3] see [RL15]
	assign cnt_last = (count_q == COUNT_ONE);
	assign b_cond = b_ok && (!cnt_en || cnt_last); // see [RL4] see [RL6]
	assign fire_b = b_cond;
	assign fire_a = match_a && !seq_sel; // see [RL3]
	assign count = count_q;
	// ==========================================
	// Counter: a bus write wins over the decrement
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= COUNT_RESET; // see [RL8]
		end else if (cnt_wr) begin
			count_q <= cnt_wdata;
		end else if (cnt_en && b_ok && count_q != COUNT_RESET) begin
			count_q <= count_q - COUNT_ONE; // see [RL5]
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			a_seen_q <= 1'b0;
		end else if (!seq_sel || b_cond) begin
			a_seen_q <= 1'b0; // see [RL15]
		end else if (match_a) begin
			a_seen_q <= 1'b1; // see [RL15]
		end
	end
endmodule : bct_count_break
`default_nettype wire

// >>> rtl/bct_top.sv
// Top of the break count and branch trace block with Avalon-MM register slave
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`default_nettype none
// Operation
// [RL1] Timing bit: 0 break before, 1 after
// [RL2] Reserved bits read zero, written zero
// [RL3] Sequence bit: independent or A then B
// [RL4] Count enable gates the count break
// [RL5] Each channel B match decrements count
// [RL6] Break on match once count is one
// [RL7] Software programs twelve-bit count, max 4095
// [RL8] Count register 16 bits, resets to zero; the count here is 12 bits wide
// [RL9] Branch captures low 28 source address bits
// [RL10] Valid flag set on every branch
// [RL11] Valid clears on read, trace enable, reset
// [RL12] Address bits keep no reset value
// [RL13] Four-entry queue shifts at every branch
// [RL14] Satisfied conditions request break and flag
// [RL15] Sequential B counts only after A
module bct_top
	import bct_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic match_a,
	input wire logic match_b,
	input wire logic insn_done,
	input wire logic branch,
	input wire logic [27:0] branch_addr,
	output logic break_req,
	output logic flag_a,
	output logic flag_b,
	output logic irq
);
	// ==========================================
	// Registers
	bct_bus_state_t state_q;
	logic timing_q;
	logic seq_q;
	logic cnt_en_q;
	logic trace_en_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [31:0] rdata_q;
	logic wait_q;
	logic pend_after_q;
	logic break_q;
	logic flag_a_q;
	logic flag_b_q;
	logic irq_q;
	// ==========================================
	// Decode
	wire logic req;
	wire logic accept;
	wire logic wr_ctrl;
	wire logic wr_count;
	wire logic wr_stat;
	wire logic wr_mask;
	wire logic wr_trace;
	wire logic rd_src;
	wire logic trace_on;
	wire logic lo_en;
	wire logic [11:0] count;
	wire logic fire_b;
	wire logic fire_a;
	wire logic [27:0] head_addr;
	wire logic head_valid;
	wire logic brk_now;
	wire logic [IRQ_W-1:0] irq_ev;
	wire logic [31:0] rdata_d;
	wire logic take;
	wire logic b_break;
	wire logic a_flag_d;
	wire logic [IRQ_W-1:0] stat_clr;
	wire logic [IRQ_W-1:0] irq_stat_d;
	wire logic irq_d;
	wire logic sel_ctrl;
	wire logic sel_count;
	wire logic sel_src;
	wire logic sel_stat;
	wire logic sel_mask;
	wire logic sel_trace;
	wire logic mapped;
	wire logic [31:0] word_ctrl;
	wire logic [31:0] word_count;
	wire logic [31:0] word_src;
	wire logic [31:0] word_stat;
	wire logic [31:0] word_mask;
	wire logic [31:0] word_trace;
	assign req = avs_read || avs_write;
	// Answer in the cycle after the request is seen
	assign accept = req && state_q == BCT_ANSWER;
	assign lo_en = avs_byteenable[0];
	assign wr_ctrl = accept && avs_write && avs_address == OFF_CTRL && lo_en;
	assign wr_count = accept && avs_write && avs_address == OFF_COUNT && lo_en;
	assign wr_stat = accept && avs_write && avs_address == OFF_IRQ_STAT && lo_en;
	assign wr_mask = accept && avs_write && avs_address == OFF_IRQ_MASK && lo_en;
	assign wr_trace = accept && avs_write && avs_address == OFF_TRACE && lo_en;
	// Request seen in idle: read word captured, waitrequest drops next cycle
	assign take = req && state_q == BCT_IDLE;
	// Head valid clears at the capturing edge, so a branch in between cannot lose an unread entry
	assign rd_src = take && avs_read && avs_address == OFF_SRC; // see [RL11]
	assign trace_on = wr_trace && avs_writedata[BIT_TRACE_EN] && !trace_en_q; // see [RL11]
	// Before-execution breaks fire at match, after-execution ones wait for completion
	assign b_break = (fire_b && !timing_q) || (pend_after_q && insn_done); // see [RL1]
	assign brk_now = b_break || fire_a; // see [RL14]
	// Channel A flag also marks a sequential A-then-B break, in step with the request
	assign a_flag_d = fire_a || (seq_q && b_break); // see [RL14]
	assign irq_ev = {branch, fire_b && cnt_en_q, brk_now};
	// Set wins over write-one-to-clear
	assign stat_clr = wr_stat ? avs_writedata[IRQ_W-1:0] : IRQ_RESET;
	assign irq_stat_d = (irq_stat_q & ~stat_clr) | irq_ev;
	assign irq_d = |(irq_stat_d & irq_mask_q);
	// ==========================================
	// Read multiplexer
	assign word_ctrl = {25'h000_0000, timing_q, 2'b00, seq_q, 2'b00, cnt_en_q}; // see [RL2]
	assign word_count = {20'h0_0000, count}; // see [RL2] see [RL8]
	assign word_src = {head_valid, 3'b000, head_addr}; // see [RL2]
	assign word_stat = {29'h0000_0000, irq_stat_q};
	assign word_mask = {29'h0000_0000, irq_mask_q};
	assign word_trace = {31'h0000_0000, trace_en_q};
	assign sel_ctrl = avs_address == OFF_CTRL;
	assign sel_count = avs_address == OFF_COUNT;
	assign sel_src = avs_address == OFF_SRC;
	assign sel_stat = avs_address == OFF_IRQ_STAT;
	assign sel_mask = avs_address == OFF_IRQ_MASK;
	assign sel_trace = avs_address == OFF_TRACE;
	assign mapped = sel_ctrl || sel_count || sel_src || sel_stat || sel_mask || sel_trace;
	assign rdata_d =
		({32{sel_ctrl}} & word_ctrl) |
		({32{sel_count}} & word_count) |
		({32{sel_src}} & word_src) |
		({32{sel_stat}} & word_stat) |
		({32{sel_mask}} & word_mask) |
		({32{sel_trace}} & word_trace) |
		({32{!mapped}} & UNMAPPED_DATA);
	// ==========================================
	// Submodules
	bct_count_break u_count (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.match_a(match_a),
		.match_b(match_b),
		.seq_sel(seq_q),
		.cnt_en(cnt_en_q),
		.cnt_wr(wr_count),
		.cnt_wdata(avs_writedata[CNT_W-1:0]), // see [RL7]
		.count(count),
		.fire_b(fire_b),
		.fire_a(fire_a)
	);
	bct_src_queue u_queue (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.branch(branch),
		.branch_addr(branch_addr),
		.clear_head(rd_src),
		.clear_all(trace_on),
		.head_addr(head_addr),
		.head_valid(head_valid)
	);
	// ==========================================
	// Bus slave
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= BCT_IDLE;
		end else begin
			case (state_q)
				BCT_IDLE: state_q <= req ? BCT_ANSWER : BCT_IDLE;
				BCT_ANSWER: state_q <= BCT_IDLE;
				default: state_q <= BCT_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !take;
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= UNMAPPED_DATA;
		end else if (take) begin
			rdata_q <= rdata_d;
		end
	end
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	// ==========================================
	// Control registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			timing_q <= 1'b0;
		end else if (wr_ctrl) begin
			timing_q <= avs_writedata[BIT_TIMING]; // see [RL1]
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			seq_q <= 1'b0;
		end else if (wr_ctrl) begin
			seq_q <= avs_writedata[BIT_SEQ]; // see [RL3]
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_en_q <= 1'b0;
		end else if (wr_ctrl) begin
			cnt_en_q <= avs_writedata[BIT_CNT_EN]; // see [RL4]
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			trace_en_q <= 1'b0;
		end else if (wr_trace) begin
			trace_en_q <= avs_writedata[BIT_TRACE_EN];
		end
	end
	// ==========================================
	// Break request and match flags
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pend_after_q <= 1'b0;
		end else if (fire_b && timing_q) begin
			pend_after_q <= 1'b1; // see [RL1]
		end else if (insn_done) begin
			pend_after_q <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			break_q <= 1'b0;
		end else begin
			break_q <= brk_now; // see [RL14]
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			flag_a_q <= 1'b0;
		end else begin
			flag_a_q <= a_flag_d; // see [RL14]
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			flag_b_q <= 1'b0;
		end else begin
			flag_b_q <= b_break; // see [RL14]
		end
	end
	assign break_req = break_q;
	assign flag_a = flag_a_q;
	assign flag_b = flag_b_q;
	// ==========================================
	// Interrupt status: set wins over write-one-to-clear
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_q <= IRQ_RESET;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask_q <= IRQ_RESET;
		end else if (wr_mask) begin
			irq_mask_q <= avs_writedata[IRQ_W-1:0];
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end
	assign irq = irq_q;
endmodule : bct_top
`default_nettype wire

// >>> verif/bct_top_chk.sv
// Checker: bus handshake, break pulses and reserved read bits
`default_nettype none
module bct_top_chk
	import bct_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic match_a,
	input wire logic match_b,
	input wire logic insn_done,
	input wire logic break_req,
	input wire logic flag_a,
	input wire logic flag_b
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire logic ans = avs_read && !avs_waitrequest;
	// ==========================================
	// Checks
	chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("answer late");
	chk_wait_rest: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest not raised");
	chk_break_flag: assert property (break_req |-> flag_a || flag_b)
		else $error("break without flag");
	chk_flag_break: assert property (flag_a || flag_b |-> break_req)
		else $error("flag without break");
	chk_break_cause: assert property (break_req |-> $past(match_a || match_b || insn_done))
		else $error("break without cause");
	chk_unmapped_zero: assert property (ans && avs_address == 5'h18 |-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_count_rsvd: assert property (ans && avs_address == OFF_COUNT |-> avs_readdata[31:12] == 20'h0_0000)
		else $error("count reserved bits set");
	chk_ctrl_rsvd: assert property (ans && avs_address == OFF_CTRL |-> {avs_readdata[5:4], avs_readdata[2:1]} == 4'h0)
		else $error("control reserved bits set");
	chk_src_rsvd: assert property (ans && avs_address == OFF_SRC |-> avs_readdata[30:28] == 3'h0)
		else $error("source reserved bits set");
endmodule : bct_top_chk
bind bct_top bct_top_chk bct_top_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.match_a(match_a), .match_b(match_b), .insn_done(insn_done), .break_req(break_req), .flag_a(flag_a),
	.flag_b(flag_b));
`default_nettype wire

// >>> verif/bct_cpu_model.sv
// CPU core model: completes a matched instruction and counts break requests
`default_nettype none
module bct_cpu_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic match_b,
	input wire logic break_req,
	output logic insn_done,
	output logic [7:0] breaks
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] pipe_q;
	// Matched instruction finishes two cycles after its fetch
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pipe_q <= 2'h0;
			breaks <= 8'h00;
		end else begin
			pipe_q <= {pipe_q[0], match_b};
			breaks <= breaks + {7'h00, break_req};
		end
	end
	assign insn_done = pipe_q[1];
endmodule : bct_cpu_model
`default_nettype wire

// >>> verif/bct_top_tb.sv
// Testbench of the break count and branch trace block
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module bct_top_tb;
	import bct_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, reset_n = 0, avs_read = 0, avs_write = 0, match_a = 0, match_b = 0, branch = 0;
	logic [4:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, q;
	logic [27:0] branch_addr = 0;
	logic avs_waitrequest, insn_done, break_req, irq;
	int err_total = 0, checks_done = 0, cyc = 0;
	logic [7:0] breaks;
	logic [3:0] avs_byteenable = 4'hf;
	always #5 clk_sys = ~clk_sys;
	bct_top bct_top_inst (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .match_a(match_a), .match_b(match_b), .insn_done(insn_done),
		.branch(branch), .branch_addr(branch_addr), .break_req(break_req), .flag_a(), .flag_b(), .irq(irq));
	bct_cpu_model bct_cpu_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .match_b(match_b),
		.break_req(break_req), .insn_done(insn_done), .breaks(breaks));
	// ==========================================
	// Tasks
	task automatic print_verdict;
		if (err_total == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(q, e)
	endtask : rd
	task automatic ev(input logic a, input logic b, input logic br, input logic [27:0] ad);
		@(posedge clk_sys);
		match_a <= a;
		match_b <= b;
		branch <= br;
		branch_addr <= ad;
		@(posedge clk_sys);
		{match_a, match_b, branch} <= 3'h0;
		repeat (4) @(posedge clk_sys);
	endtask : ev
	always @(posedge clk_sys) if (++cyc == 3000) begin err_total++; print_verdict; end
	// ==========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(OFF_CTRL, 32'h0000_0000);
		rd(OFF_COUNT, 32'h0000_0000);
		rd(OFF_IRQ_STAT, 32'h0000_0000);
		bus(1'b1, OFF_CTRL, 32'h0000_0049);
		rd(OFF_CTRL, 32'h0000_0049);
		bus(1'b1, OFF_COUNT, 32'h0000_0fff);
		rd(OFF_COUNT, 32'h0000_0fff);
		bus(1'b1, OFF_CTRL, 32'h0000_0000);
		ev(0, 1, 0, 0);
		`CHK(breaks, 8'h01)
		bus(1'b1, OFF_CTRL, 32'h0000_0040);
		ev(0, 1, 0, 0);
		`CHK(breaks, 8'h02)
		bus(1'b1, OFF_CTRL, 32'h0000_0008);
		ev(0, 1, 0, 0);
		ev(1, 0, 0, 0);
		`CHK(breaks, 8'h02)
		ev(0, 1, 0, 0);
		`CHK(breaks, 8'h03)
		bus(1'b1, OFF_COUNT, 32'h0000_0003);
		bus(1'b1, OFF_CTRL, 32'h0000_0001);
		ev(0, 1, 0, 0);
		ev(0, 1, 0, 0);
		`CHK(breaks, 8'h03)
		rd(OFF_COUNT, 32'h0000_0001);
		ev(0, 1, 0, 0);
		`CHK(breaks, 8'h04)
		for (int i = 1; i < 5; i++) ev(0, 0, 1, 28'hbcd_ef00 + 28'(i));
		rd(OFF_SRC, 32'h8bcd_ef01);
		rd(OFF_SRC, 32'h0bcd_ef01);
		ev(0, 0, 1, 28'hbcd_ef05);
		rd(OFF_SRC, 32'h8bcd_ef02);
		rd(OFF_IRQ_STAT, 32'h0000_0007);
		`CHK(irq, 1'b0)
		bus(1'b1, OFF_IRQ_MASK, 32'h0000_0004);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b1)
		bus(1'b1, OFF_IRQ_STAT, 32'h0000_0004);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		rd(OFF_IRQ_STAT, 32'h0000_0003);
		ev(0, 0, 1, 28'hbcd_ef06);
		bus(1'b1, OFF_TRACE, 32'h0000_0001);
		bus(1'b0, OFF_SRC, 32'h0000_0000);
		`CHK(q[31], 1'b0)
		bus(1'b1, 5'h18, 32'h0000_0001);
		rd(5'h18, 32'h0000_0000);
		avs_byteenable <= 4'he;
		bus(1'b1, OFF_COUNT, 32'h0000_0005);
		avs_byteenable <= 4'hf;
		rd(OFF_COUNT, 32'h0000_0000);
		print_verdict;
	end
endmodule : bct_top_tb
`default_nettype wire
